// >>> src/ife_pkg.sv
// Purpose: constants for the interrupt flag and enable logic
// Assumes: one 20 MHz clock, synchronous active-low reset
// Notes:   register indexes on the plain register port, bit positions

package ife_pkg;

  // register indexes on the plain register port
  localparam logic [2:0] IFE_ADDR_CORE    = 3'h0;
  localparam logic [2:0] IFE_ADDR_PENABLE = 3'h1;
  localparam logic [2:0] IFE_ADDR_PREQ    = 3'h2;
  localparam logic [2:0] IFE_ADDR_PINEN   = 3'h3;
  localparam logic [2:0] IFE_ADDR_EDGE    = 3'h4;

  // core control bit positions
  localparam int IFE_GLOBAL_EN_BIT = 7;
  localparam int IFE_GROUP_EN_BIT  = 6;
  localparam int IFE_TZ_EN_BIT     = 5;
  localparam int IFE_EXTIE_BIT     = 4;
  localparam int IFE_PCIE_BIT      = 3;
  localparam int IFE_TZ_FLAG_BIT   = 2;
  localparam int IFE_EXTIF_BIT     = 1;
  localparam int IFE_PCIF_BIT      = 0;

  // peripheral enable / request bit positions (same in both)
  localparam int IFE_ADC_BIT = 6;
  localparam int IFE_CCP_BIT = 5;
  localparam int IFE_C2_BIT  = 4;
  localparam int IFE_C1_BIT  = 3;
  localparam int IFE_T2_BIT  = 1;
  localparam int IFE_T1_BIT  = 0;

  // edge select position in its own register
  localparam int IFE_EDGE_BIT = 6;

  // implemented-bit masks and reset values
  localparam logic [7:0] IFE_PERIPH_MASK = 8'h7b;
  localparam logic [5:0] IFE_PINEN_MASK  = 6'h3f;
  localparam logic [7:0] IFE_CORE_RST    = 8'h00;
  localparam logic [7:0] IFE_PERIPH_RST  = 8'h00;
  localparam logic [5:0] IFE_PINEN_RST   = 6'h00;
  localparam logic       IFE_EDGE_RST    = 1'b1;

  // capture/compare unit modes
  typedef enum logic [1:0] {
    IFE_CCP_OFF     = 2'b00,
    IFE_CCP_CAPTURE = 2'b01,
    IFE_CCP_COMPARE = 2'b10,
    IFE_CCP_PWM     = 2'b11
  } ife_ccp_mode_t;

endpackage

// >>> src/ife_ctrl.sv
// Purpose: interrupt flags, enables and the single request to the core
// Assumes: event inputs are synchronous to clk; pulses are one cycle long
// Notes:   registers on a plain port, read data valid the cycle after the strobe
//
// Contract
// - global enable bit 7 gates every interrupt request to the core.
// - peripheral group enable bit 6 must be set for peripheral requests.
// - flags set on their event regardless of any enable bit.
// - timer-zero flag bit 2 sets on rollover, holds until written zero.
// - timer-zero count survives reset; firmware loads it before clearing flag.
// - external pin flag sets on its event, holds until cleared.
// - port change flag sets when any of pins 5..0 changes.
// - port change request also needs the per-pin change enable.
// - core bits 5, 4, 3 enable timer-zero, external pin, port change.
// - peripheral enables at bits 6, 5, 4, 3, 1, 0.
// - bits 7 and 2 of peripheral registers read zero.
// - peripheral flags sit at the same positions as their enables.
// - converter flag bit 6 sets when a conversion completes.
// - capture/compare flag sets on capture or compare match, unused in pwm.
// - comparator flags bits 4 and 3 set when comparator output changes.
// - timer-two flag bit 1 sets on period match.
// - timer-one flag bit 0 sets on timer-one overflow.
// - external flag triggers on rising edge if select is one, else falling.
//
// Local design decisions: the strobed register port and the register offsets.

`timescale 1ns/1ns

module ife_ctrl
  import ife_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // core event sources
  input  wire logic       timer_zero_rollover,
  input  wire logic       external_irq_pin,
  input  wire logic [5:0] gpio_port_a,
  // peripheral event sources
  input  wire logic       converter_done,
  input  wire logic [1:0] ccp_mode,
  input  wire logic       ccp_capture,
  input  wire logic       ccp_compare_match,
  input  wire logic       comparator_one_out,
  input  wire logic       comparator_two_out,
  input  wire logic       timer_two_match,
  input  wire logic       timer_one_overflow,
  // request to the core
  output logic            irq_req
);

  // register state
  logic [7:0] core_interrupt_control_ff;
  logic [7:0] peripheral_interrupt_enable_ff;
  logic [7:0] peripheral_interrupt_request_ff;
  logic [5:0] per_pin_change_enable_ff;
  logic       external_edge_select_ff;
  logic [5:0] pin_changed_ff;
  logic [7:0] rdata_ff;
  // previous samples for edge and change detection
  logic       ext_pin_prev_ff;
  logic [5:0] port_prev_ff;
  logic       cmp_one_prev_ff;
  logic       cmp_two_prev_ff;
  // next values
  logic [7:0] nxt_core;
  logic [7:0] nxt_preq;
  logic [5:0] nxt_pin_changed;
  logic [7:0] nxt_rdata;
  // decoded strobes and events
  logic       wr_core;
  logic       wr_penable;
  logic       wr_preq;
  logic       ext_event;
  logic [5:0] port_change;
  logic [7:0] periph_event;
  logic       core_pending;
  logic       periph_pending;

  // sticky flag: hardware set wins over a software clear in the same cycle
  function automatic logic sticky(input logic cur, input logic wr,
                                  input logic wbit, input logic ev);
    sticky = (wr ? wbit : cur) | ev;
  endfunction

  // address decode for writes
  assign wr_core    = reg_wr && (reg_addr == IFE_ADDR_CORE);
  assign wr_penable = reg_wr && (reg_addr == IFE_ADDR_PENABLE);
  assign wr_preq    = reg_wr && (reg_addr == IFE_ADDR_PREQ);

  // external pin edge, polarity from the select bit
  assign ext_event = external_edge_select_ff ?
                     (external_irq_pin & ~ext_pin_prev_ff) :
                     (~external_irq_pin & ext_pin_prev_ff);

  // any pin of 5..0 that toggled since last cycle
  assign port_change = gpio_port_a ^ port_prev_ff;

  // peripheral events placed at their flag positions
  always_comb begin
    periph_event              = 8'h00;
    periph_event[IFE_ADC_BIT] = converter_done;
    periph_event[IFE_CCP_BIT] = (ccp_mode == IFE_CCP_CAPTURE && ccp_capture) ||
                                (ccp_mode == IFE_CCP_COMPARE && ccp_compare_match);
    periph_event[IFE_C2_BIT]  = comparator_two_out ^ cmp_two_prev_ff;
    periph_event[IFE_C1_BIT]  = comparator_one_out ^ cmp_one_prev_ff;
    periph_event[IFE_T2_BIT]  = timer_two_match;
    periph_event[IFE_T1_BIT]  = timer_one_overflow;
  end

  // core register next value; flags set ignoring every enable
  always_comb begin
    nxt_core = wr_core ? reg_wdata : core_interrupt_control_ff;
    nxt_core[IFE_TZ_FLAG_BIT] = sticky(core_interrupt_control_ff[IFE_TZ_FLAG_BIT],
                                       wr_core, reg_wdata[IFE_TZ_FLAG_BIT],
                                       timer_zero_rollover);
    nxt_core[IFE_EXTIF_BIT] = sticky(core_interrupt_control_ff[IFE_EXTIF_BIT], wr_core,
                                     reg_wdata[IFE_EXTIF_BIT], ext_event);
    nxt_core[IFE_PCIF_BIT] = sticky(core_interrupt_control_ff[IFE_PCIF_BIT], wr_core,
                                    reg_wdata[IFE_PCIF_BIT], |port_change);
  end

  // per-pin change memory, cleared along with the port change flag
  always_comb begin
    nxt_pin_changed = pin_changed_ff;
    if (wr_core && !reg_wdata[IFE_PCIF_BIT]) begin
      nxt_pin_changed = 6'h00;
    end
    nxt_pin_changed = nxt_pin_changed | port_change;
  end

  // peripheral request next value, unimplemented bits forced low
  always_comb begin
    nxt_preq = peripheral_interrupt_request_ff;
    for (int i = 0; i < 8; i++) begin
      nxt_preq[i] = sticky(peripheral_interrupt_request_ff[i], wr_preq,
                           reg_wdata[i], periph_event[i]);
    end
    nxt_preq = nxt_preq & IFE_PERIPH_MASK;
  end

  // core control register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      core_interrupt_control_ff <= IFE_CORE_RST;
    end else begin
      core_interrupt_control_ff <= nxt_core;
    end
  end

  // peripheral enable register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      peripheral_interrupt_enable_ff <= IFE_PERIPH_RST;
    end else if (wr_penable) begin
      peripheral_interrupt_enable_ff <= reg_wdata & IFE_PERIPH_MASK;
    end
  end

  // peripheral request register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      peripheral_interrupt_request_ff <= IFE_PERIPH_RST;
    end else begin
      peripheral_interrupt_request_ff <= nxt_preq;
    end
  end

  // per-pin change enables and edge select
  always_ff @(posedge clk) begin
    if (!resetn) begin
      per_pin_change_enable_ff <= IFE_PINEN_RST;
      external_edge_select_ff  <= IFE_EDGE_RST;
    end else begin
      if (reg_wr && reg_addr == IFE_ADDR_PINEN) begin
        per_pin_change_enable_ff <= reg_wdata[5:0] & IFE_PINEN_MASK;
      end
      if (reg_wr && reg_addr == IFE_ADDR_EDGE) begin
        external_edge_select_ff <= reg_wdata[IFE_EDGE_BIT];
      end
    end
  end

  // pin change memory
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin_changed_ff <= 6'h00;
    end else begin
      pin_changed_ff <= nxt_pin_changed;
    end
  end

  // previous samples; loaded during reset so release raises no false change
  always_ff @(posedge clk) begin
    ext_pin_prev_ff <= external_irq_pin;
    port_prev_ff    <= gpio_port_a;
    cmp_one_prev_ff <= comparator_one_out;
    cmp_two_prev_ff <= comparator_two_out;
  end

  // read mux; unmapped indexes read zero
  always_comb begin
    unique case (reg_addr)
      IFE_ADDR_CORE:    nxt_rdata = core_interrupt_control_ff;
      IFE_ADDR_PENABLE: nxt_rdata = peripheral_interrupt_enable_ff;
      IFE_ADDR_PREQ:    nxt_rdata = peripheral_interrupt_request_ff;
      IFE_ADDR_PINEN:   nxt_rdata = {2'b00, per_pin_change_enable_ff};
      IFE_ADDR_EDGE:    nxt_rdata = {1'b0, external_edge_select_ff, 6'h00};
      default:          nxt_rdata = 8'h00;
    endcase
  end

  // read data stands only in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= reg_rd ? nxt_rdata : 8'h00;
    end
  end
  assign reg_rdata = rdata_ff;

  // core source pairs; port change needs a pin that is also enabled per pin
  // the timer-zero counter lives outside and is never touched by this reset
  assign core_pending =
    (core_interrupt_control_ff[IFE_TZ_EN_BIT] & core_interrupt_control_ff[IFE_TZ_FLAG_BIT]) |
    (core_interrupt_control_ff[IFE_EXTIE_BIT] & core_interrupt_control_ff[IFE_EXTIF_BIT]) |
    (core_interrupt_control_ff[IFE_PCIE_BIT] & core_interrupt_control_ff[IFE_PCIF_BIT] &
     |(pin_changed_ff & per_pin_change_enable_ff));

  // peripheral pairs behind the group enable
  assign periph_pending = core_interrupt_control_ff[IFE_GROUP_EN_BIT] &
    |(peripheral_interrupt_enable_ff & peripheral_interrupt_request_ff);

  // single request, combinational so the core sees a flag the cycle it sets
  assign irq_req = core_interrupt_control_ff[IFE_GLOBAL_EN_BIT] &
                   (core_pending | periph_pending);

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  global_gate_a: assert property (
    !core_interrupt_control_ff[IFE_GLOBAL_EN_BIT] |-> !irq_req)
    else $error("request raised while global enable clear");

  group_gate_a: assert property (
    !core_interrupt_control_ff[IFE_GROUP_EN_BIT] && !core_pending |-> !irq_req)
    else $error("peripheral request without group enable");

  t0_flag_set_a: assert property (
    timer_zero_rollover |=> core_interrupt_control_ff[IFE_TZ_FLAG_BIT])
    else $error("timer-zero flag missed rollover");

  flag_holds_a: assert property (
    core_interrupt_control_ff[IFE_TZ_FLAG_BIT] && !wr_core
      |=> core_interrupt_control_ff[IFE_TZ_FLAG_BIT])
    else $error("timer-zero flag dropped without a write");

  ext_edge_a: assert property (
    external_edge_select_ff && !$past(external_irq_pin) && external_irq_pin
      |=> core_interrupt_control_ff[IFE_EXTIF_BIT])
    else $error("rising edge did not set external flag");

  ext_fall_a: assert property (
    !external_edge_select_ff && $past(external_irq_pin) && !external_irq_pin
      |=> core_interrupt_control_ff[IFE_EXTIF_BIT])
    else $error("falling edge did not set external flag");

  port_change_a: assert property (
    gpio_port_a != $past(gpio_port_a) |=> core_interrupt_control_ff[IFE_PCIF_BIT])
    else $error("pin change did not set port change flag");

  pin_enable_a: assert property (
    per_pin_change_enable_ff == 6'h00 && !periph_pending &&
    !core_interrupt_control_ff[IFE_TZ_FLAG_BIT] && !core_interrupt_control_ff[IFE_EXTIF_BIT]
      |-> !irq_req)
    else $error("port change request without per-pin enable");

  t0_request_a: assert property (
    core_interrupt_control_ff[IFE_GLOBAL_EN_BIT] && core_interrupt_control_ff[IFE_TZ_EN_BIT] &&
    core_interrupt_control_ff[IFE_TZ_FLAG_BIT] |-> irq_req)
    else $error("enabled timer-zero flag gave no request");

  unimpl_zero_a: assert property (
    reg_rd && (reg_addr == IFE_ADDR_PENABLE || reg_addr == IFE_ADDR_PREQ)
      |=> reg_rdata[7] == 1'b0 && reg_rdata[2] == 1'b0)
    else $error("unimplemented peripheral bit read as one");

  ccp_flag_a: assert property (
    ccp_mode == IFE_CCP_PWM && !wr_preq && !peripheral_interrupt_request_ff[IFE_CCP_BIT]
      |=> !peripheral_interrupt_request_ff[IFE_CCP_BIT])
    else $error("capture/compare flag set in pwm mode");

  cmp_flag_a: assert property (
    comparator_one_out != $past(comparator_one_out)
      |=> peripheral_interrupt_request_ff[IFE_C1_BIT])
    else $error("comparator one change missed");

  cmp_two_flag_a: assert property (
    comparator_two_out != $past(comparator_two_out)
      |=> peripheral_interrupt_request_ff[IFE_C2_BIT])
    else $error("comparator two change missed");

  t2_flag_set_a: assert property (
    timer_two_match |=> peripheral_interrupt_request_ff[IFE_T2_BIT])
    else $error("timer-two flag missed period match");

  t1_flag_set_a: assert property (
    timer_one_overflow |=> peripheral_interrupt_request_ff[IFE_T1_BIT])
    else $error("timer-one flag missed overflow");

  periph_hold_a: assert property (
    peripheral_interrupt_request_ff[IFE_T1_BIT] && !wr_preq
      |=> peripheral_interrupt_request_ff[IFE_T1_BIT])
    else $error("timer-one flag dropped without a write");

  periph_req_a: assert property (
    |(peripheral_interrupt_enable_ff & peripheral_interrupt_request_ff) &&
    core_interrupt_control_ff[IFE_GROUP_EN_BIT] && core_interrupt_control_ff[IFE_GLOBAL_EN_BIT]
      |-> irq_req)
    else $error("enabled peripheral pair gave no request");

  adc_read_a: assert property (
    converter_done ##2 reg_rd && reg_addr == IFE_ADDR_PREQ && !$past(wr_preq)
      |=> reg_rdata[IFE_ADC_BIT])
    else $error("converter flag not visible on read");

  reset_zero_a: assert property (@(posedge clk) disable iff (1'b0)
    !resetn |=> core_interrupt_control_ff == 8'h00 &&
                peripheral_interrupt_request_ff == 8'h00 && reg_rdata == 8'h00)
    else $error("registers not cleared by reset");

  clear_race_c: cover property (wr_core && !reg_wdata[IFE_TZ_FLAG_BIT] && timer_zero_rollover);
  t0_irq_c:     cover property ($rose(irq_req) && core_interrupt_control_ff[IFE_TZ_FLAG_BIT]);
  ext_fall_c:   cover property ($rose(core_interrupt_control_ff[IFE_EXTIF_BIT]) &&
                                !external_edge_select_ff);
  periph_irq_c: cover property ($rose(irq_req) && periph_pending);
  port_irq_c:   cover property ($rose(irq_req) && core_pending && pin_changed_ff != 6'h00);

endmodule

// >>> testbench/ife_src_model.sv
// Purpose: event sources on the far side of the interrupt logic
// Assumes: bench calls the tasks; outputs change just after clk edges
// Notes:   timer-zero count has no reset, like the real counter
`timescale 1ns/1ns

module ife_src_model (
  // clock
  input  wire logic clk,
  // core event sources
  output logic       timer_zero_rollover = 1'b0,
  output logic       external_irq_pin    = 1'b0,
  output logic [5:0] gpio_port_a         = 6'h00,
  // peripheral event sources
  output logic       converter_done      = 1'b0,
  output logic [1:0] ccp_mode            = 2'h0,
  output logic       ccp_capture         = 1'b0,
  output logic       ccp_compare_match   = 1'b0,
  output logic       comparator_one_out  = 1'b0,
  output logic       comparator_two_out  = 1'b0,
  output logic       timer_two_match     = 1'b0,
  output logic       timer_one_overflow  = 1'b0
);
  logic [7:0] tz_count;        // never reset, keeps its value
  logic       tz_run = 1'b0;

  // count while running; one-cycle pulse as the count wraps
  always @(posedge clk) begin
    if (tz_run) begin
      tz_count <= tz_count + 8'h01;
      timer_zero_rollover <= (tz_count == 8'hff);
    end else begin
      timer_zero_rollover <= 1'b0;
    end
  end

  // known count loaded before the flag is relied on
  task automatic load_tz(input logic [7:0] v, input logic run);
    @(posedge clk);
    tz_count <= v;
    tz_run   <= run;
  endtask

  // one-cycle event pulse
  task automatic pulse(input int k);
    @(posedge clk);
    case (k)
      0: timer_one_overflow <= 1'b1;
      1: timer_two_match <= 1'b1;
      2: ccp_compare_match <= 1'b1;
      5: ccp_capture <= 1'b1;
      default: converter_done <= 1'b1;
    endcase
    @(posedge clk);
    {converter_done, ccp_capture, ccp_compare_match} <= 3'h0;
    {timer_two_match, timer_one_overflow} <= 2'h0;
  endtask

  // level sources
  task automatic set_lv(input int k, input logic [5:0] v);
    @(posedge clk);
    case (k)
      0: external_irq_pin <= v[0];
      1: gpio_port_a <= v;
      2: ccp_mode <= v[1:0];
      3: comparator_one_out <= v[0];
      default: comparator_two_out <= v[0];
    endcase
  endtask
endmodule

// >>> testbench/test_interrupt_flag_enable_logic.sv
// Purpose: self-checking bench for the interrupt flag and enable logic
// Assumes: 50 ns clock, reset held 16 cycles
// Notes:   firmware side is played by the register tasks
`timescale 1ns/1ns

module test_interrupt_flag_enable_logic import ife_pkg::*; ;
  logic       clk, resetn, reg_wr, reg_rd, irq_req;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, got, b;
  logic       tzr, ext, cdn, cap, cmpm, c1, c2, t2, t1;
  logic [5:0] gpa;
  logic [1:0] mode;
  logic [4:3] cmp_lv = 2'b00;
  int         error_cnt = 0;
  int         total_checks = 0;
  int         bits[6] = '{0, 1, 3, 4, 5, 6};

  ife_src_model i_ife_src_model (.clk(clk), .timer_zero_rollover(tzr), .external_irq_pin(ext),
    .gpio_port_a(gpa), .converter_done(cdn), .ccp_mode(mode), .ccp_capture(cap),
    .ccp_compare_match(cmpm), .comparator_one_out(c1), .comparator_two_out(c2),
    .timer_two_match(t2), .timer_one_overflow(t1));
  ife_ctrl i_ife_ctrl (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_zero_rollover(tzr),
    .external_irq_pin(ext), .gpio_port_a(gpa), .converter_done(cdn), .ccp_mode(mode),
    .ccp_capture(cap), .ccp_compare_match(cmpm), .comparator_one_out(c1),
    .comparator_two_out(c2), .timer_two_match(t2), .timer_one_overflow(t1), .irq_req(irq_req));

  // clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic ichk(input logic e);
    #1 chk({7'h00, irq_req}, {7'h00, e});
  endtask
  // comparators fire on a level change, the rest on a pulse
  task automatic fire(input int k);
    if (k == 3 || k == 4) begin
      cmp_lv[k] = ~cmp_lv[k];
      i_ife_src_model.set_lv(k, {5'h00, cmp_lv[k]});
      @(posedge clk);
    end else begin
      i_ife_src_model.pulse(k);
    end
  endtask
  task automatic test_done();
    $display("checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #2000000;
    error_cnt++;
    test_done();
  end

  initial begin
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    // reset values, unmapped index
    rchk(IFE_ADDR_CORE, 8'h00);
    rchk(IFE_ADDR_PENABLE, 8'h00);
    rchk(IFE_ADDR_PREQ, 8'h00);
    rchk(IFE_ADDR_PINEN, 8'h00);
    rchk(IFE_ADDR_EDGE, 8'h01 << IFE_EDGE_BIT);
    wr(3'h5, 8'hff);
    rchk(3'h5, 8'h00);
    $display("test reset done");
    // all ones written, unimplemented bits read zero
    wr(IFE_ADDR_PENABLE, 8'hff);
    rchk(IFE_ADDR_PENABLE, IFE_PERIPH_MASK);
    wr(IFE_ADDR_PREQ, 8'hff);
    rchk(IFE_ADDR_PREQ, IFE_PERIPH_MASK);
    wr(IFE_ADDR_PINEN, 8'hff);
    rchk(IFE_ADDR_PINEN, {2'b00, IFE_PINEN_MASK});
    wr(IFE_ADDR_CORE, 8'hff);
    rchk(IFE_ADDR_CORE, 8'hff);
    ichk(1'b1);
    wr(IFE_ADDR_CORE, 8'h7f);
    ichk(1'b0);
    wr(IFE_ADDR_CORE, 8'hbf);
    ichk(1'b1);
    wr(IFE_ADDR_CORE, 8'h80);
    ichk(1'b0);
    $display("test access done");
    // global gating, then the enable of each of the six peripheral sources
    wr(IFE_ADDR_CORE, 8'h40);
    ichk(1'b0);
    wr(IFE_ADDR_PREQ, 8'h00);
    wr(IFE_ADDR_CORE, 8'hc0);
    i_ife_src_model.set_lv(2, IFE_CCP_CAPTURE);
    foreach (bits[i]) begin
      b = 8'h01 << bits[i];
      wr(IFE_ADDR_PENABLE, IFE_PERIPH_MASK & ~b);
      fire(bits[i]);
      ichk(1'b0);
      rchk(IFE_ADDR_PREQ, b);
      wr(IFE_ADDR_PENABLE, b);
      ichk(1'b1);
      wr(IFE_ADDR_PREQ, 8'h00);
      ichk(1'b0);
    end
    $display("test peripheral done");
    // capture/compare events count only in their own mode
    for (int m = 0; m < 4; m++) begin
      i_ife_src_model.set_lv(2, m[5:0]);
      i_ife_src_model.pulse(5);
      i_ife_src_model.pulse(2);
      rchk(IFE_ADDR_PREQ, (m == 1 || m == 2) ? 8'h20 : 8'h00);
      wr(IFE_ADDR_PREQ, 8'h00);
    end
    wr(IFE_ADDR_CORE, 8'h00);
    $display("test capture done");
    // external pin edge select
    i_ife_src_model.set_lv(0, 6'h01);
    rchk(IFE_ADDR_CORE, 8'h02);
    wr(IFE_ADDR_CORE, 8'h00);
    i_ife_src_model.set_lv(0, 6'h00);
    rchk(IFE_ADDR_CORE, 8'h00);
    wr(IFE_ADDR_EDGE, 8'h00);
    i_ife_src_model.set_lv(0, 6'h01);
    rchk(IFE_ADDR_CORE, 8'h00);
    i_ife_src_model.set_lv(0, 6'h00);
    rchk(IFE_ADDR_CORE, 8'h02);
    wr(IFE_ADDR_CORE, 8'h8a);
    ichk(1'b0);
    wr(IFE_ADDR_CORE, 8'h92);
    ichk(1'b1);
    $display("test external done");
    // port change needs the per-pin enable of a changed pin
    wr(IFE_ADDR_CORE, 8'h00);
    wr(IFE_ADDR_PINEN, 8'h08);
    i_ife_src_model.set_lv(1, 6'h01);
    rchk(IFE_ADDR_CORE, 8'h01);
    wr(IFE_ADDR_CORE, 8'h89);
    ichk(1'b0);
    wr(IFE_ADDR_CORE, 8'h88);
    i_ife_src_model.set_lv(1, 6'h09);
    @(posedge clk);
    ichk(1'b1);
    $display("test port change done");
    // timer-zero rollover, flag holds until written zero
    wr(IFE_ADDR_CORE, 8'h00);
    i_ife_src_model.load_tz(8'hfe, 1'b1);
    repeat (3) @(posedge clk);
    i_ife_src_model.load_tz(8'h00, 1'b0);
    rchk(IFE_ADDR_CORE, 8'h04);
    wr(IFE_ADDR_CORE, 8'ha4);
    ichk(1'b1);
    wr(IFE_ADDR_CORE, 8'ha0);
    ichk(1'b0);
    $display("test timer zero done");
    // second reset in mid-run
    wr(IFE_ADDR_PREQ, 8'hff);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rchk(IFE_ADDR_CORE, 8'h00);
    rchk(IFE_ADDR_PREQ, 8'h00);
    ichk(1'b0);
    $display("test second reset done");
    test_done();
  end
endmodule
